// [verilog/srsm_top.sv]
// reset combiner, supply monitor filter, stabilization wait and oscillator gate
// assumes fault pulses and pins synchronous to sys_clk
`include "srsm_defines.svh"
module srsm_top
	import srsm_pkg::*;
#(
	parameter int LV_FILTER_CYC = `SRSM_LV_FILTER_CYC,
	parameter int WAIT_CYC      = `SRSM_WAIT_CYC
)
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// supply monitor comparator, high while supply at or below threshold
	input  wire logic        supply_low,
	// fault causes from the core
	input  wire srsm_fault_s fault,
	// standby status and stop request and release from the core
	input  wire logic        standby_active,
	input  wire logic        stop_request,
	input  wire logic        stop_release,
	// pins reflected into the high port register
	input  wire logic [3:0]  key_input,
	input  wire logic        sense_input_2,
	// reset outputs to the core
	output logic             sys_reset,
	output logic             core_hold,
	output logic             keep_data_regs,
	output logic             osc_enable,
	output srsm_core_s       core_init
);
	srsm_regs_s r_r;
	srsm_regs_s r_nxt;

	localparam logic [16:0] LV_LAST   = 17'(LV_FILTER_CYC - 1);
	localparam logic [9:0]  WAIT_LAST = 10'(WAIT_CYC - 1);

	function automatic srsm_core_s core_reset_value(input logic [3:0] keys, input logic sense);
		srsm_core_s c;
		c = '0;
		c.program_counter = `SRSM_PC_RST;
		c.data_pointer    = `SRSM_DP_RST;
		c.timer           = `SRSM_TMR_RST;
		c.stack_pointer   = 1'b0;
		c.status_flag     = 1'b0;
		c.carry_flag      = 1'b0;
		c.high_port_register = `SRSM_HP_FIXED_VAL;
		c.high_port_register[`SRSM_HP_KEY_LSB +: 4] = keys;
		c.high_port_register[`SRSM_HP_SENSE_BIT]    = sense;
		return c;
	endfunction

	logic any_fault;
	assign any_fault = fault.standby_bad | fault.rotate_zero | fault.stack_fault;

	always_comb
	begin
		r_nxt = r_r;
		r_nxt.sys_reset = 1'b0;
		// dips shorter than the filter are ignored, trading latency for noise immunity
		if (!supply_low)
		begin
			r_nxt.lv_cnt   = '0;
			r_nxt.lv_reset = 1'b0;
		end
		else if (r_r.lv_cnt >= LV_LAST)
			r_nxt.lv_reset = 1'b1;
		else
			r_nxt.lv_cnt = r_r.lv_cnt + 17'h0001;
		if (standby_active)
			r_nxt.standby_seen = 1'b1;
		else if (r_r.state == SRSM_RUN)
			r_nxt.standby_seen = 1'b0;
		if (r_nxt.lv_reset || any_fault)
		begin
			r_nxt.sys_reset  = 1'b1;
			r_nxt.core_hold  = 1'b1;
			r_nxt.osc_enable = 1'b0;
			r_nxt.wait_cnt   = '0;
			r_nxt.core       = core_reset_value(key_input, sense_input_2);
			// data registers survive only a supply reset taken in standby
			if (r_r.state != SRSM_RESET)
				r_nxt.keep_data = r_nxt.lv_reset && !any_fault && r_r.standby_seen;
			r_nxt.state = SRSM_RESET;
		end
		else
		begin
			case (r_r.state)
				SRSM_RESET:
				begin
					r_nxt.osc_enable = 1'b1;
					r_nxt.state      = SRSM_WAIT;
				end
				SRSM_WAIT:
				begin
					if (r_r.wait_cnt >= WAIT_LAST)
					begin
						r_nxt.core_hold = 1'b0;
						r_nxt.state     = SRSM_RUN;
					end
					else
						r_nxt.wait_cnt = r_r.wait_cnt + 10'h001;
				end
				SRSM_RUN:
				begin
					if (stop_request)
					begin
						r_nxt.osc_enable = 1'b0;
						r_nxt.core_hold  = 1'b1;
						r_nxt.state      = SRSM_STOP;
					end
				end
				SRSM_STOP:
				begin
					if (stop_release)
					begin
						r_nxt.osc_enable = 1'b1;
						r_nxt.wait_cnt   = '0;
						r_nxt.state      = SRSM_WAIT;
					end
				end
				default:
					r_nxt.state = SRSM_RESET;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			r_r            <= '0;
			r_r.state      <= SRSM_RESET;
			r_r.sys_reset  <= 1'b1;
			r_r.core_hold  <= 1'b1;
			r_r.core.high_port_register <= `SRSM_HP_FIXED_VAL;
		end
		else
			r_r <= r_nxt;
	end

	assign sys_reset      = r_r.sys_reset;
	assign core_hold      = r_r.core_hold;
	assign keep_data_regs = r_r.keep_data;
	assign osc_enable     = r_r.osc_enable;
	assign core_init      = r_r.core;
endmodule

// [verilog/srsm_defines.svh]
// constants for the system reset and supply monitor block
// assumes a 125 MHz sys_clk; included by srsm_pkg and the top module
`ifndef SRSM_DEFINES_SVH
`define SRSM_DEFINES_SVH
`define SRSM_CLK_MHZ        125
`define SRSM_LV_FILTER_US   1000
`define SRSM_LV_FILTER_CYC  (`SRSM_LV_FILTER_US * `SRSM_CLK_MHZ)
`define SRSM_WAIT_MIN       252
`define SRSM_WAIT_MAX       700
`define SRSM_WAIT_CYC       `SRSM_WAIT_MIN
`define SRSM_PC_RST         11'h000
`define SRSM_DP_RST         8'h00
`define SRSM_TMR_RST        10'h000
`define SRSM_HP_FIXED_MASK  8'h0D
`define SRSM_HP_FIXED_VAL   8'h0D
`define SRSM_HP_KEY_LSB     4
`define SRSM_HP_SENSE_BIT   1
`endif

// [verilog/srsm_pkg.sv]
// types shared by the system reset and supply monitor block
`include "srsm_defines.svh"
package srsm_pkg;
	typedef enum logic [3:0]
	{
		SRSM_RESET = 4'b0001,
		SRSM_WAIT  = 4'b0010,
		SRSM_RUN   = 4'b0100,
		SRSM_STOP  = 4'b1000
	} srsm_state_e;

	// fault causes raised by the core, one-cycle pulses
	typedef struct packed
	{
		logic standby_bad;
		logic rotate_zero;
		logic stack_fault;
	} srsm_fault_s;

	// core state forced on reset
	typedef struct packed
	{
		logic [10:0] program_counter;
		logic [7:0]  data_pointer;
		logic [9:0]  timer;
		logic        stack_pointer;
		logic        status_flag;
		logic        carry_flag;
		logic [7:0]  high_port_register;
	} srsm_core_s;

	typedef struct packed
	{
		srsm_state_e state;
		logic [16:0] lv_cnt;
		logic [9:0]  wait_cnt;
		logic        lv_reset;
		logic        sys_reset;
		logic        core_hold;
		logic        osc_enable;
		logic        keep_data;
		logic        standby_seen;
		srsm_core_s  core;
	} srsm_regs_s;
endpackage

// [testbench/srsm_properties.sv]
// checker for srsm_top, bound to its ports
// assumes faults reach it only while the core runs
module srsm_properties import srsm_pkg::*;
#(
	parameter int LV_FILTER_CYC = 8,
	parameter int WAIT_CYC      = 4
)
(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        nrst,
	// causes
	input wire logic        supply_low,
	input wire srsm_fault_s fault,
	// outputs
	input wire logic        sys_reset,
	input wire logic        core_hold,
	input wire logic        keep_data_regs,
	input wire logic        osc_enable,
	input wire srsm_core_s  core_init
);
	timeunit 1ns;
	timeprecision 1ps;
	int lv_r;
	int hold_r;
	// saturating, so a long brown-out cannot wrap the count
	always_ff @(posedge sys_clk)
	begin
		lv_r <= (!nrst || !supply_low) ? 0 : lv_r + int'(lv_r <= LV_FILTER_CYC);
		hold_r <= (!nrst || sys_reset || !core_hold) ? 0 : hold_r + 1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	fault_rst_a: assert property (|fault |=> sys_reset) else $error("no reset");
	rst_end_a: assert property (!supply_low && !(|fault) [*2] |=> !sys_reset) else $error("stuck");
	osc_off_a: assert property (sys_reset |-> !osc_enable) else $error("osc on");
	hold_on_a: assert property (sys_reset |-> core_hold) else $error("not held");
	core_clr_a: assert property (sys_reset |-> core_init[39:8] == '0) else $error("not cleared");
	port_fix_a: assert property (sys_reset |-> (core_init[3:0] & 4'hD) == 4'hD) else $error("port");
	lv_hold_a: assert property (lv_r > LV_FILTER_CYC |-> sys_reset) else $error("lv missed");
	lv_early_a: assert property ($rose(sys_reset) |-> $past(|fault) || lv_r >= LV_FILTER_CYC - 1)
		else $error("lv early");
	wait_len_a: assert property ($fell(core_hold) |-> hold_r >= WAIT_CYC - 1) else $error("short");
	keep_clr_a: assert property (|fault && !supply_low |=> !keep_data_regs) else $error("kept");
	fault_c: cover property (|fault ##1 sys_reset);
	lv_c: cover property (lv_r > LV_FILTER_CYC);
	run_c: cover property ($fell(core_hold));
endmodule
bind srsm_top srsm_properties #(.LV_FILTER_CYC(LV_FILTER_CYC), .WAIT_CYC(WAIT_CYC)) i_chk (.*);

// [testbench/srsm_core_model.sv]
// core model: raises fault causes on request
// assumes req is driven by the bench off the clock edge
module srsm_core_model import srsm_pkg::*;
(
	// request and hold
	input  wire srsm_fault_s req,
	input  wire logic        core_hold,
	// cause out
	output srsm_fault_s      fault
);
	timeunit 1ns;
	timeprecision 1ps;
	// a held core executes nothing, so it cannot fault
	assign fault = core_hold ? '0 : req;
endmodule

// [testbench/srsm_top_tb.sv]
// bench for srsm_top: supply, fault and stop scenarios
// assumes short filter (8) and wait (4) counts
module srsm_top_tb import srsm_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 0, nrst = 0, supply_low = 0, standby_active = 0;
	logic        stop_request = 0, stop_release = 0, sense_input_2 = 1;
	logic [3:0]  key_input = 4'h5;
	srsm_fault_s fault, req = '0;
	logic        sys_reset, core_hold, keep_data_regs, osc_enable;
	srsm_core_s  core_init;
	int          bad_count = 0, samples_checked = 0, n;
	always #4 sys_clk = ~sys_clk;
	srsm_core_model i_srsm_core_model (.*);
	srsm_top #(.LV_FILTER_CYC(8), .WAIT_CYC(4)) i_srsm_top (.*);
	task automatic tk(int k); repeat (k) @(posedge sys_clk); #1; endtask
	task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
		samples_checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic run_wait;
		for (n = 0; core_hold !== 1'b0 && n < 99; n++)
			tk(1);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#9000;
		bad_count++;
		close_out;
	end
	initial
	begin
		tk(10);
		nrst = 1;
		run_wait;
		supply_low = 1;
		tk(6);
		chk("dip", 0, sys_reset);
		supply_low = 0;
		standby_active = 1;
		tk(2);
		supply_low = 1;
		tk(11);
		chk("lv", 1, sys_reset);
		supply_low = 0;
		standby_active = 0;
		tk(3);
		chk("lv off", 0, sys_reset);
		run_wait;
		chk("keep", 1, keep_data_regs);
		$display("supply test done");
		for (int i = 0; i < 3; i++)
		begin
			req = srsm_fault_s'(3'(3'h1 << i));
			tk(1);
			req = '0;
			chk("rst", 1, sys_reset);
			chk("osc", 0, osc_enable);
			chk("init", 40'h00_0000_005F, core_init);
			tk(1);
			chk("pulse", 0, sys_reset);
			chk("osc", 1, osc_enable);
			run_wait;
			chk("wait", 4, n);
			chk("keep", 0, keep_data_regs);
		end
		$display("fault test done");
		stop_request = 1;
		tk(1);
		stop_request = 0;
		tk(2);
		chk("stop", 0, osc_enable);
		stop_release = 1;
		tk(1);
		stop_release = 0;
		run_wait;
		chk("resume", 1, osc_enable);
		$display("stop test done");
		close_out;
	end
endmodule
